// file: pkg/dacirq_map.vh
`ifndef DACIRQ_MAP_VH
`define DACIRQ_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DACIRQ_ADDR_W 8
`define DACIRQ_OFS_ENABLE_A 8'h03
`define DACIRQ_OFS_ENABLE_B 8'h04
`define DACIRQ_OFS_FLAGS_A 8'h05
`define DACIRQ_OFS_FLAGS_B 8'h06
`define DACIRQ_OFS_ROUTE_A 8'h07
`define DACIRQ_OFS_ROUTE_B 8'h08

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define DACIRQ_DATA_W 8
`define DACIRQ_A_W 7
`define DACIRQ_B_W 3
`define DACIRQ_RST_A 7'h00
`define DACIRQ_RST_B 3'h0
`define DACIRQ_RDATA_IDLE 8'h00

// ----------------------------------------
// Bit positions, group a
// ----------------------------------------
`define DACIRQ_BIT_ALIGN_LOSS 6
`define DACIRQ_BIT_ALIGN_LOCKED 5
`define DACIRQ_BIT_ALIGN_COMPLETE 4
`define DACIRQ_BIT_MULT_UNLOCK 3
`define DACIRQ_BIT_MULT_LOCK 2
`define DACIRQ_BIT_POWER_LIMIT 1
`define DACIRQ_BIT_OUT_SILENCED 0

// ----------------------------------------
// Bit positions, group b
// ----------------------------------------
`define DACIRQ_BIT_BUF_UNDERRUN 2
`define DACIRQ_BIT_BUF_OVERRUN 1
`define DACIRQ_BIT_BUF_MARGIN 0

// ----------------------------------------
// Input buffer geometry and margins
// ----------------------------------------
`define DACIRQ_BUF_DEPTH 8
`define DACIRQ_BUF_PTR_W 4
`define DACIRQ_MARGIN_LOW 4'h1
`define DACIRQ_MARGIN_HIGH 4'h6
`define DACIRQ_OCC_EMPTY 4'h0
`define DACIRQ_OCC_FULL 4'h8

`endif

// file: hw/dacirq_flag_cell.v
`timescale 1ns/1ps

module dacirq_flag_cell #(
  parameter W = 7
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire [W-1:0] set_i,
  input wire [W-1:0] clr_i,
  output wire [W-1:0] flags_o
);

  // ----------------------------------------
  // Sticky flag bits
  // ----------------------------------------
  // One register per bit so no vector has several driving blocks
  genvar gi;
  generate
    for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
      reg flag_q;
      reg flag_d;

      // Set beats clear so a coincident event is never lost
      always @* begin
        if (set_i[gi]) begin
          flag_d = 1'b1;
        end else if (clr_i[gi]) begin
          flag_d = 1'b0;
        end else begin
          flag_d = flag_q;
        end
      end

      always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          flag_q <= 1'b0; // see RULE_16
        end else begin
          flag_q <= flag_d; // see RULE_16
        end
      end

      assign flags_o[gi] = flag_q;
    end
  endgenerate

endmodule // dacirq_flag_cell

// file: hw/dacirq_top.v
// Contract
// RULE_01: Flag a bit 6 sets when multi-chip alignment is lost.
// RULE_02: Flag a bit 5 sets when multi-chip alignment becomes locked.
// RULE_03: Flag a bit 4 sets when an alignment procedure completes.
// RULE_04: Flag a bit 3 sets when the clock multiplier loses lock.
// RULE_05: Flag a bit 2 sets when the clock multiplier achieves lock.
// RULE_06: Flag a bit 1 sets when input power exceeds its threshold.
// RULE_07: Flag a bit 0 sets whenever the output is muted at midscale.
// RULE_08: Flag b bit 2 sets when the buffer read pointer catches the write pointer.
// RULE_09: Flag b bit 1 sets when the buffer write pointer catches the read pointer.
// RULE_10: Flag b bit 0 sets when buffer occupancy is at most 1 or at least 6.
// RULE_11: Route a bits steer each group a event to the first pin on 0, the second on 1.
// RULE_12: Route b bits 2 to 0 steer each buffer event to the first pin on 0, the second on 1.
// RULE_13: Enable a at 0x03 holds one read-write enable per group a event, reset 0.
// RULE_14: Enable b at 0x04 holds one read-write enable per buffer event, reset 0.
// RULE_15: A pin is asserted while any set flag that is enabled and routed to it exists.
// RULE_16: Flags clear on reset and stay set until cleared by the clearing write.
`timescale 1ns/1ps
`include "dacirq_map.vh"

module dacirq_top #(
  parameter BUF_PTR_W = `DACIRQ_BUF_PTR_W
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  // Register port
  input wire [`DACIRQ_ADDR_W-1:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [`DACIRQ_DATA_W-1:0] reg_wdata_i,
  input wire reg_rd_i,
  output wire [`DACIRQ_DATA_W-1:0] reg_rdata_o,
  // Event sources, same clock
  input wire align_lost_i,
  input wire align_locked_i,
  input wire align_complete_i,
  input wire mult_unlocked_i,
  input wire mult_locked_i,
  input wire power_over_i,
  input wire output_muted_i,
  // Input buffer pointers, extra wrap bit
  input wire buf_wr_i,
  input wire buf_rd_i,
  input wire [BUF_PTR_W-1:0] buf_wr_ptr_i,
  input wire [BUF_PTR_W-1:0] buf_rd_ptr_i,
  // Interrupt pins, active low
  output wire first_interrupt_pin_n_o,
  output wire second_interrupt_pin_n_o,
  // Flag state for the rest of the chip
  output wire [`DACIRQ_A_W-1:0] event_flags_a_o,
  output wire [`DACIRQ_B_W-1:0] event_flags_b_o
);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  reg [`DACIRQ_A_W-1:0] event_enable_a_q;
  reg [`DACIRQ_B_W-1:0] event_enable_b_q;
  reg [`DACIRQ_A_W-1:0] event_route_a_q;
  reg [`DACIRQ_B_W-1:0] event_route_b_q;
  reg [`DACIRQ_DATA_W-1:0] rdata_q;
  reg [`DACIRQ_DATA_W-1:0] rdata_d;
  reg first_pin_q;
  reg second_pin_q;

  wire wr_enable_a;
  wire wr_enable_b;
  wire wr_flags_a;
  wire wr_flags_b;
  wire wr_route_a;
  wire wr_route_b;

  assign wr_enable_a = reg_wr_i && (reg_addr_i == `DACIRQ_OFS_ENABLE_A);
  assign wr_enable_b = reg_wr_i && (reg_addr_i == `DACIRQ_OFS_ENABLE_B);
  assign wr_flags_a = reg_wr_i && (reg_addr_i == `DACIRQ_OFS_FLAGS_A);
  assign wr_flags_b = reg_wr_i && (reg_addr_i == `DACIRQ_OFS_FLAGS_B);
  assign wr_route_a = reg_wr_i && (reg_addr_i == `DACIRQ_OFS_ROUTE_A);
  assign wr_route_b = reg_wr_i && (reg_addr_i == `DACIRQ_OFS_ROUTE_B);

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      event_enable_a_q <= `DACIRQ_RST_A; // see RULE_13
    end else if (wr_enable_a) begin
      event_enable_a_q <= reg_wdata_i[`DACIRQ_A_W-1:0]; // see RULE_13
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      event_enable_b_q <= `DACIRQ_RST_B; // see RULE_14
    end else if (wr_enable_b) begin
      event_enable_b_q <= reg_wdata_i[`DACIRQ_B_W-1:0]; // see RULE_14
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      event_route_a_q <= `DACIRQ_RST_A;
    end else if (wr_route_a) begin
      event_route_a_q <= reg_wdata_i[`DACIRQ_A_W-1:0]; // see RULE_11
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      event_route_b_q <= `DACIRQ_RST_B;
    end else if (wr_route_b) begin
      event_route_b_q <= reg_wdata_i[`DACIRQ_B_W-1:0]; // see RULE_12
    end
  end

  // ----------------------------------------
  // Group a event sources
  // ----------------------------------------
  // Level sources: a flag keeps setting while the condition holds
  reg [`DACIRQ_A_W-1:0] set_a;

  always @* begin
    set_a = `DACIRQ_RST_A;
    set_a[`DACIRQ_BIT_ALIGN_LOSS] = align_lost_i; // see RULE_01
    set_a[`DACIRQ_BIT_ALIGN_LOCKED] = align_locked_i; // see RULE_02
    set_a[`DACIRQ_BIT_ALIGN_COMPLETE] = align_complete_i; // see RULE_03
    set_a[`DACIRQ_BIT_MULT_UNLOCK] = mult_unlocked_i; // see RULE_04
    set_a[`DACIRQ_BIT_MULT_LOCK] = mult_locked_i; // see RULE_05
    set_a[`DACIRQ_BIT_POWER_LIMIT] = power_over_i; // see RULE_06
    set_a[`DACIRQ_BIT_OUT_SILENCED] = output_muted_i; // see RULE_07
  end

  // ----------------------------------------
  // Input buffer watch
  // ----------------------------------------
  // Wrap bit tells full from empty when the low bits match
  wire [BUF_PTR_W-1:0] buf_occ;
  wire buf_empty;
  wire buf_full;
  wire buf_underrun;
  wire buf_overrun;
  wire buf_margin;
  reg [`DACIRQ_B_W-1:0] set_b;

  assign buf_occ = buf_wr_ptr_i - buf_rd_ptr_i;
  assign buf_empty = (buf_occ == `DACIRQ_OCC_EMPTY);
  assign buf_full = (buf_occ == `DACIRQ_OCC_FULL);
  assign buf_underrun = buf_rd_i && !buf_wr_i && buf_empty; // see RULE_08
  assign buf_overrun = buf_wr_i && !buf_rd_i && buf_full; // see RULE_09
  assign buf_margin = (buf_occ <= `DACIRQ_MARGIN_LOW) || (buf_occ >= `DACIRQ_MARGIN_HIGH); // see RULE_10

  always @* begin
    set_b = `DACIRQ_RST_B;
    set_b[`DACIRQ_BIT_BUF_UNDERRUN] = buf_underrun; // see RULE_08
    set_b[`DACIRQ_BIT_BUF_OVERRUN] = buf_overrun; // see RULE_09
    set_b[`DACIRQ_BIT_BUF_MARGIN] = buf_margin; // see RULE_10
  end

  // ----------------------------------------
  // Flag registers
  // ----------------------------------------
  // Writing a one to a flag bit clears it; set still wins
  wire [`DACIRQ_A_W-1:0] clr_a;
  wire [`DACIRQ_B_W-1:0] clr_b;
  wire [`DACIRQ_A_W-1:0] flags_a;
  wire [`DACIRQ_B_W-1:0] flags_b;

  assign clr_a = wr_flags_a ? reg_wdata_i[`DACIRQ_A_W-1:0] : `DACIRQ_RST_A; // see RULE_16
  assign clr_b = wr_flags_b ? reg_wdata_i[`DACIRQ_B_W-1:0] : `DACIRQ_RST_B; // see RULE_16

  dacirq_flag_cell #(
    .W(`DACIRQ_A_W)
  ) u_flags_a (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .set_i(set_a),
    .clr_i(clr_a),
    .flags_o(flags_a)
  );

  dacirq_flag_cell #(
    .W(`DACIRQ_B_W)
  ) u_flags_b (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .set_i(set_b),
    .clr_i(clr_b),
    .flags_o(flags_b)
  );

  assign event_flags_a_o = flags_a;
  assign event_flags_b_o = flags_b;

  // ----------------------------------------
  // Pin routing
  // ----------------------------------------
  // Enables gate only the pins; flags update regardless
  wire [`DACIRQ_A_W-1:0] live_a;
  wire [`DACIRQ_B_W-1:0] live_b;
  wire first_pin_d;
  wire second_pin_d;

  assign live_a = flags_a & event_enable_a_q; // see RULE_15
  assign live_b = flags_b & event_enable_b_q; // see RULE_15
  assign first_pin_d = |(live_a & ~event_route_a_q) || |(live_b & ~event_route_b_q); // see RULE_11
  assign second_pin_d = |(live_a & event_route_a_q) || |(live_b & event_route_b_q); // see RULE_12

  // Registered so the pins never glitch while routing changes
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      first_pin_q <= 1'b0;
      second_pin_q <= 1'b0;
    end else begin
      first_pin_q <= first_pin_d; // see RULE_15
      second_pin_q <= second_pin_d; // see RULE_15
    end
  end

  assign first_interrupt_pin_n_o = ~first_pin_q;
  assign second_interrupt_pin_n_o = ~second_pin_q;

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  // Unmapped offsets and reserved bits read as zero
  always @* begin
    rdata_d = `DACIRQ_RDATA_IDLE;
    case (reg_addr_i)
      `DACIRQ_OFS_ENABLE_A: begin
        rdata_d[`DACIRQ_A_W-1:0] = event_enable_a_q;
      end
      `DACIRQ_OFS_ENABLE_B: begin
        rdata_d[`DACIRQ_B_W-1:0] = event_enable_b_q;
      end
      `DACIRQ_OFS_FLAGS_A: begin
        rdata_d[`DACIRQ_A_W-1:0] = flags_a;
      end
      `DACIRQ_OFS_FLAGS_B: begin
        rdata_d[`DACIRQ_B_W-1:0] = flags_b;
      end
      `DACIRQ_OFS_ROUTE_A: begin
        rdata_d[`DACIRQ_A_W-1:0] = event_route_a_q;
      end
      `DACIRQ_OFS_ROUTE_B: begin
        rdata_d[`DACIRQ_B_W-1:0] = event_route_b_q;
      end
      default: begin
        rdata_d = `DACIRQ_RDATA_IDLE;
      end
    endcase
  end

  // Data holds until the next read strobe
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_q <= `DACIRQ_RDATA_IDLE;
    end else if (reg_rd_i) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule // dacirq_top

// file: test/dacirq_top_sva.sv
`timescale 1ns/1ps
`include "dacirq_map.vh"
module dacirq_top_sva #(
  parameter BUF_PTR_W = 4
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire [`DACIRQ_ADDR_W-1:0] reg_addr_i,
  input wire reg_wr_i,
  input wire align_lost_i,
  input wire mult_locked_i,
  input wire output_muted_i,
  input wire buf_wr_i,
  input wire buf_rd_i,
  input wire [BUF_PTR_W-1:0] buf_wr_ptr_i,
  input wire [BUF_PTR_W-1:0] buf_rd_ptr_i,
  input wire first_interrupt_pin_n_o,
  input wire second_interrupt_pin_n_o,
  input wire [`DACIRQ_A_W-1:0] event_flags_a_o,
  input wire [`DACIRQ_B_W-1:0] event_flags_b_o
);
  // Wrap bit makes full and empty distinct
  wire [BUF_PTR_W-1:0] occ = buf_wr_ptr_i - buf_rd_ptr_i;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_lost_sets: assert property (align_lost_i |=> event_flags_a_o[6])
    else $error("align loss flag not set");
  a_lock_sets: assert property (mult_locked_i |=> event_flags_a_o[2])
    else $error("multiplier lock flag not set");
  a_muted_sets: assert property (output_muted_i |=> event_flags_a_o[0])
    else $error("silenced flag not set");
  a_underrun_sets: assert property (buf_rd_i && !buf_wr_i && occ == 0 |=> event_flags_b_o[2])
    else $error("underrun flag not set");
  a_overrun_sets: assert property (buf_wr_i && !buf_rd_i && occ == 8 |=> event_flags_b_o[1])
    else $error("overrun flag not set");
  a_margin_sets: assert property (occ <= 1 || occ >= 6 |=> event_flags_b_o[0])
    else $error("margin flag not set");
  a_flags_hold: assert property (!(reg_wr_i && reg_addr_i == `DACIRQ_OFS_FLAGS_A) |=>
    (event_flags_a_o & $past(event_flags_a_o)) == $past(event_flags_a_o))
    else $error("flag dropped without clear");
  a_pins_idle: assert property (event_flags_a_o == 0 && event_flags_b_o == 0 |=>
    first_interrupt_pin_n_o && second_interrupt_pin_n_o)
    else $error("pin asserted with no flag");
endmodule // dacirq_top_sva
bind dacirq_top dacirq_top_sva #(.BUF_PTR_W(BUF_PTR_W)) dacirq_top_sva_inst (.clk_sys_i, .rst_n_i,
  .reg_addr_i, .reg_wr_i, .align_lost_i, .mult_locked_i, .output_muted_i, .buf_wr_i, .buf_rd_i,
  .buf_wr_ptr_i, .buf_rd_ptr_i, .first_interrupt_pin_n_o, .second_interrupt_pin_n_o,
  .event_flags_a_o, .event_flags_b_o);

// file: test/dacirq_host.sv
`timescale 1ns/1ps
module dacirq_host (
  input wire clk_sys_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
  end
  // One-cycle strobe; idle address inverted so stale values never look valid
  task automatic access(input logic w, input logic [7:0] a, d);
    @(posedge clk_sys_i);
    reg_wr_o <= w;
    reg_rd_o <= !w;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
endmodule // dacirq_host

// file: test/dacirq_top_tb.sv
`timescale 1ns/1ps
`include "dacirq_map.vh"
module dacirq_top_tb;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [6:0] ev = 7'h00;
  logic [3:0] wp = 4'h3;
  logic [3:0] rp = 4'h0;
  logic bwr = 1'b0;
  logic brd = 1'b0;
  wire [7:0] addr, wdata, rdata;
  wire bus_wr, bus_rd, pin1_n, pin2_n;
  logic [9:0] exp_q[$];
  logic [31:0] seed = 32'h0ef8_bd94;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  dacirq_host dacirq_host_inst (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wr_o(bus_wr),
    .reg_wdata_o(wdata), .reg_rd_o(bus_rd));
  dacirq_top dacirq_top_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(bus_wr),
    .reg_wdata_i(wdata), .reg_rd_i(bus_rd), .reg_rdata_o(rdata), .align_lost_i(ev[6]), .align_locked_i(ev[5]),
    .align_complete_i(ev[4]), .mult_unlocked_i(ev[3]), .mult_locked_i(ev[2]), .power_over_i(ev[1]),
    .output_muted_i(ev[0]), .buf_wr_i(bwr), .buf_rd_i(brd), .buf_wr_ptr_i(wp), .buf_rd_ptr_i(rp),
    .first_interrupt_pin_n_o(pin1_n), .second_interrupt_pin_n_o(pin2_n), .event_flags_a_o(),
    .event_flags_b_o());
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic stop_test();
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [9:0] e, g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] pins_rdata exp %h got %h", e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    dacirq_host_inst.access(1'b1, a, d);
  endtask
  // Expected value is {first pin, second pin, read data}
  task automatic rd(input logic [7:0] a, d, input logic [1:0] p);
    exp_q.push_back({p, d});
    dacirq_host_inst.access(1'b0, a, 8'h00);
  endtask
  task automatic bcase(input logic [3:0] w, r, input logic bw, br, input logic [2:0] e);
    logic [7:0] en;
    logic [7:0] rt;
    en = 8'(rnd());
    rt = 8'(rnd());
    wr(`DACIRQ_OFS_ENABLE_B, en);
    wr(`DACIRQ_OFS_ROUTE_B, rt);
    @(posedge clk_sys_i);
    wp <= w;
    rp <= r;
    bwr <= bw;
    brd <= br;
    @(posedge clk_sys_i);
    wp <= 4'h3;
    rp <= 4'h0;
    bwr <= 1'b0;
    brd <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rd(`DACIRQ_OFS_FLAGS_B, {5'h00, e}, ~{|(e & en[2:0] & ~rt[2:0]), |(e & en[2:0] & rt[2:0])});
    wr(`DACIRQ_OFS_FLAGS_B, 8'h07);
    rd(`DACIRQ_OFS_FLAGS_B, 8'h00, 2'b11);
  endtask
  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (bus_rd) begin
      @(negedge clk_sys_i);
      check(exp_q.pop_front(), {pin1_n, pin2_n, rdata});
    end
  end
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] en;
    logic [7:0] rt;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int a = 3; a < 10; a++) rd(a[7:0], 8'h00, 2'b11);
    wr(`DACIRQ_OFS_ENABLE_A, 8'hff);
    wr(`DACIRQ_OFS_ENABLE_B, 8'hff);
    wr(8'h09, 8'hff);
    rd(`DACIRQ_OFS_ENABLE_A, 8'h7f, 2'b11);
    rd(`DACIRQ_OFS_ENABLE_B, 8'h07, 2'b11);
    rd(8'h09, 8'h00, 2'b11);
    for (int i = 0; i < 7; i++) begin
      en = 8'(rnd());
      rt = 8'(rnd());
      wr(`DACIRQ_OFS_ENABLE_A, en);
      wr(`DACIRQ_OFS_ROUTE_A, rt);
      rd(`DACIRQ_OFS_ROUTE_A, rt & 8'h7f, 2'b11);
      @(posedge clk_sys_i);
      ev <= 7'h01 << i;
      @(posedge clk_sys_i);
      ev <= 7'h00;
      repeat (2) @(posedge clk_sys_i);
      rd(`DACIRQ_OFS_FLAGS_A, 8'h01 << i, ~{en[i] & ~rt[i], en[i] & rt[i]});
      wr(`DACIRQ_OFS_FLAGS_A, 8'h01 << i);
      rd(`DACIRQ_OFS_FLAGS_A, 8'h00, 2'b11);
    end
    bcase(4'h5, 4'h5, 1'b0, 1'b1, 3'h5);
    bcase(4'h5, 4'h5, 1'b1, 1'b1, 3'h1);
    bcase(4'ha, 4'h2, 1'b1, 1'b0, 3'h3);
    bcase(4'h6, 4'h0, 1'b0, 1'b0, 3'h1);
    bcase(4'h1, 4'h0, 1'b0, 1'b0, 3'h1);
    bcase(4'h5, 4'h0, 1'b0, 1'b0, 3'h0);
    bcase(4'h2, 4'h0, 1'b0, 1'b0, 3'h0);
    repeat (3) @(posedge clk_sys_i);
    stop_test();
  end
endmodule // dacirq_top_tb
